//--- hdl/bst_pkg.sv
package bst_pkg;

  // instruction width and codes
  localparam int unsigned      IR_W          = 3;
  localparam logic [IR_W-1:0]  INS_EXTEST    = 3'h0;
  localparam logic [IR_W-1:0]  INS_IDCODE    = 3'h1;
  localparam logic [IR_W-1:0]  INS_SAMPLE_Z  = 3'h2;
  localparam logic [IR_W-1:0]  INS_SAMPLE    = 3'h4;
  localparam logic [IR_W-1:0]  INS_BYPASS    = 3'h7;
  // value loaded into the instruction shifter on capture
  localparam logic [IR_W-1:0]  IR_CAPTURE    = 3'h1;

  // data register sizes and fixed positions
  localparam int unsigned      ID_W          = 32;
  localparam int unsigned      BSR_LEN_DEF   = 109;
  localparam int unsigned      OE_CELL       = 108;
  // identification value, arbitrary
  localparam logic [ID_W-1:0]  ID_VALUE_DEF  = 32'h1234_5001;

  // synchroniser depth and reset levels of the test pins
  localparam int unsigned      SYNC_STAGES   = 2;
  localparam logic [2:0]       PIN_RESET     = 3'h6;

  // controller states, neighbours in this list differ in one bit
  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SEL_DR  = 4'h3,
    ST_CAP_DR  = 4'h2,
    ST_SHF_DR  = 4'h6,
    ST_EX1_DR  = 4'h7,
    ST_PAU_DR  = 4'h5,
    ST_EX2_DR  = 4'h4,
    ST_UPD_DR  = 4'hC,
    ST_SEL_IR  = 4'hD,
    ST_CAP_IR  = 4'hF,
    ST_SHF_IR  = 4'hE,
    ST_EX1_IR  = 4'hA,
    ST_PAU_IR  = 4'hB,
    ST_EX2_IR  = 4'h9,
    ST_UPD_IR  = 4'h8
  } bst_state_e;

  // test port pins as seen from the board
  typedef struct packed {
    logic tms;
    logic tdi;
    logic tck;
  } bst_pins_s;

endpackage : bst_pkg

//--- hdl/bst_sync.sv
`timescale 1ns/1ps
module bst_sync #(
  parameter int unsigned       WIDTH = 1,
  parameter logic [WIDTH-1:0]  RESET = '0
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  import bst_pkg::*;

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_chk
    $error("bst_sync: WIDTH must be at least 1");
  end

  // two flops; only the second reads the first
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      meta_q <= RESET;
      o_sync <= RESET;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : bst_sync

//--- hdl/bst_tap.sv
`timescale 1ns/1ps
// What this block does
// - sample on test clock rise, drive on fall
// - mode select steers controller, idles high
// - serial in enters selected register MSB
// - serial out from LSB, driven only shifting
// - five high mode edges reset test logic
// - power-up reset floats serial out
// - one register selected, per held instruction
// - three-bit instruction, reset loads identify
// - instruction capture loads pattern 01
// - one-bit bypass, cleared on capture
// - boundary captures pins, then shifts them
// - boundary chain MSB in, LSB out
// - identify captures fixed 32-bit value
// - instruction takes effect at update state
// - sample-z selects boundary, floats output bus
// - cell 108 gates outputs in extest, preset high
module bst_tap #(
  parameter int unsigned           BSR_LEN  = bst_pkg::BSR_LEN_DEF,
  parameter logic [bst_pkg::ID_W-1:0] ID_VALUE = bst_pkg::ID_VALUE_DEF
) (
  input  wire logic                i_clock,
  input  wire logic                i_reset_n,
  input  wire bst_pkg::bst_pins_s  i_pins,
  input  wire logic [BSR_LEN-1:0]  i_ring,
  output logic                     o_tdo,
  output logic                     o_tdo_oe,
  output logic [BSR_LEN-1:0]       o_preload,
  output logic                     o_extest,
  output logic                     o_bus_enable
);
  import bst_pkg::*;

  bst_pins_s           pins_s;
  logic [BSR_LEN-1:0]  ring_s;
  logic                tck_prev_q;
  logic                tck_rise;
  logic                tck_fall;
  bst_state_e          state_q;
  bst_state_e          state_d;
  logic [IR_W-1:0]     ir_q;
  logic [IR_W-1:0]     ir_sr_q;
  logic                byp_q;
  logic [ID_W-1:0]     id_q;
  logic [BSR_LEN-1:0]  bsr_q;
  logic                dr_lsb;

  if (BSR_LEN <= OE_CELL) begin : g_chk
    $error("bst_tap: boundary chain must hold the output enable cell");
  end

  // selects the boundary chain
  function automatic logic uses_bsr(input logic [IR_W-1:0] ins);
    uses_bsr = (ins == INS_EXTEST) || (ins == INS_SAMPLE) || (ins == INS_SAMPLE_Z);
  endfunction : uses_bsr

  // test pins and pin ring into the clock domain
  bst_sync #(
    .WIDTH (3),
    .RESET (PIN_RESET)
  ) u_pin_sync (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_async   (i_pins),
    .o_sync    (pins_s)
  );

  bst_sync #(
    .WIDTH (BSR_LEN),
    .RESET ('0)
  ) u_ring_sync (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_async   (i_ring),
    .o_sync    (ring_s)
  );

  // test clock edge finder
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= pins_s.tck;
    end
  end

  assign tck_rise = pins_s.tck & ~tck_prev_q;
  assign tck_fall = ~pins_s.tck & tck_prev_q;

  // next controller state from mode select
  always_comb begin
    case (state_q)
      ST_RESET:  state_d = pins_s.tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_d = pins_s.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = pins_s.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = pins_s.tms ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: state_d = pins_s.tms ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: state_d = pins_s.tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_d = pins_s.tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_d = pins_s.tms ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: state_d = pins_s.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = pins_s.tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_d = pins_s.tms ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: state_d = pins_s.tms ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: state_d = pins_s.tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_d = pins_s.tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_d = pins_s.tms ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: state_d = pins_s.tms ? ST_SEL_DR : ST_IDLE;
      default:   state_d = ST_RESET;
    endcase
  end

  // controller steps on test clock rise
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_q <= ST_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // instruction shifter
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      ir_sr_q <= INS_IDCODE;
    end else if (tck_rise && state_q == ST_CAP_IR) begin
      ir_sr_q <= IR_CAPTURE;
    end else if (tck_rise && state_q == ST_SHF_IR) begin
      ir_sr_q <= {pins_s.tdi, ir_sr_q[IR_W-1:1]};
    end
  end

  // held instruction, changed only at update or reset
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      ir_q <= INS_IDCODE;
    end else if (state_q == ST_RESET) begin
      ir_q <= INS_IDCODE;
    end else if (tck_fall && state_q == ST_UPD_IR) begin
      ir_q <= ir_sr_q;
    end
  end

  // bypass bit
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      byp_q <= 1'b0;
    end else if (tck_rise && state_q == ST_CAP_DR) begin
      byp_q <= 1'b0;
    end else if (tck_rise && state_q == ST_SHF_DR) begin
      byp_q <= pins_s.tdi;
    end
  end

  // identification shifter, used only under identify
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      id_q <= '0;
    end else if (tck_rise && ir_q == INS_IDCODE) begin
      if (state_q == ST_CAP_DR) begin
        id_q <= ID_VALUE;
      end else if (state_q == ST_SHF_DR) begin
        id_q <= {pins_s.tdi, id_q[ID_W-1:1]};
      end
    end
  end

  // boundary chain, MSB faces serial in
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      bsr_q <= '0;
    end else if (tck_rise && uses_bsr(ir_q)) begin
      if (state_q == ST_CAP_DR) begin
        bsr_q <= ring_s;
      end else if (state_q == ST_SHF_DR) begin
        bsr_q <= {pins_s.tdi, bsr_q[BSR_LEN-1:1]};
      end
    end
  end

  // parallel preload stage, enable cell preset high
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || state_q == ST_RESET) begin
      o_preload          <= '0;
      o_preload[OE_CELL] <= 1'b1;
    end else if (tck_fall && state_q == ST_UPD_DR && uses_bsr(ir_q)) begin
      o_preload <= bsr_q;
    end
  end

  // output bus control from the held instruction
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_extest     <= 1'b0;
      o_bus_enable <= 1'b1;
    end else begin
      o_extest <= (ir_q == INS_EXTEST);
      if (ir_q == INS_SAMPLE_Z) begin
        o_bus_enable <= 1'b0;
      end else if (ir_q == INS_EXTEST) begin
        o_bus_enable <= o_preload[OE_CELL];
      end else begin
        o_bus_enable <= 1'b1;
      end
    end
  end

  // low end of the selected data register
  always_comb begin
    if (uses_bsr(ir_q)) begin
      dr_lsb = bsr_q[0];
    end else if (ir_q == INS_IDCODE) begin
      dr_lsb = id_q[0];
    end else begin
      dr_lsb = byp_q;
    end
  end

  // serial out moves on test clock fall
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo    <= (state_q == ST_SHF_IR) ? ir_sr_q[0] : dr_lsb;
      o_tdo_oe <= (state_q == ST_SHF_IR) || (state_q == ST_SHF_DR);
    end
  end

endmodule : bst_tap

//--- test/bst_jtag_master.sv
`timescale 1ns/1ps
module bst_jtag_master (
  input  wire logic          i_clock,
  input  wire logic          i_tdo,
  input  wire logic          i_tdo_oe,
  output bst_pkg::bst_pins_s o_pins
);
  import bst_pkg::*;
  // idle: clock low, pulled-up lines high
  initial o_pins = 3'h6;
  // one 800 ns period; data out read just before the rise
  task automatic step(input logic ms, input logic di, output logic q);
    @(negedge i_clock);
    o_pins.tms = ms;
    o_pins.tdi = di;
    repeat (3) @(negedge i_clock);
    q = i_tdo_oe ? i_tdo : 1'bz;
    o_pins.tck = 1'b1;
    repeat (4) @(negedge i_clock);
    o_pins.tck = 1'b0;
  endtask : step
endmodule : bst_jtag_master

//--- test/bst_tap_checker.sv
`timescale 1ns/1ps
module bst_tap_checker #(
  parameter int unsigned BSR_LEN = bst_pkg::BSR_LEN_DEF
) (
  input wire logic               i_clock,
  input wire logic               i_reset_n,
  input wire bst_pkg::bst_pins_s i_pins,
  input wire logic               o_tdo,
  input wire logic               o_tdo_oe,
  input wire logic [BSR_LEN-1:0] o_preload,
  input wire logic               o_extest,
  input wire logic               o_bus_enable
);
  import bst_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic       tck_q;
  logic [2:0] ones_q;
  // counts test clock rises with mode high
  always_ff @(posedge i_clock) begin
    tck_q <= i_pins.tck;
    if (!i_reset_n) ones_q <= 3'h0;
    else if (i_pins.tck && !tck_q) ones_q <= !i_pins.tms ? 3'h0 : (ones_q == 3'h5 ? 3'h5 : ones_q + 3'h1);
  end
  // output timing against the test clock
  chk_tdo_fall: assert property ($changed(o_tdo) |-> !$past(i_pins.tck, 2))
    else $error("data out moved while clock high");
  chk_oe_fall: assert property ($changed(o_tdo_oe) |-> !$past(i_pins.tck, 2))
    else $error("enable moved while clock high");
  chk_ext_fall: assert property ($rose(o_extest) |-> !$past(i_pins.tck, 3))
    else $error("instruction changed off a fall");
  chk_oe_hold: assert property ($rose(o_tdo_oe) |=> o_tdo_oe [*3])
    else $error("enable too short");
  chk_bus_gate: assert property (o_extest && $past(o_extest) && $stable(o_preload[OE_CELL])
    |-> o_bus_enable == o_preload[OE_CELL])
    else $error("bus enable not from cell");
  chk_bus_rst: assert property ($rose(i_reset_n)
    |-> o_bus_enable && o_preload[OE_CELL] && !o_extest && !o_tdo_oe)
    else $error("bad state after reset");
  chk_quiet_tck: assert property ($stable(i_pins.tck) [*8]
    |-> $stable(o_tdo_oe) && $stable(o_extest) && $stable(o_tdo))
    else $error("outputs moved without clock");
  chk_tms_reset: assert property ($rose(ones_q == 3'h5) |-> ##[1:8] (o_bus_enable && !o_extest))
    else $error("five mode highs did not reset");
endmodule : bst_tap_checker

bind bst_tap bst_tap_checker #(.BSR_LEN(BSR_LEN)) u_chk (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_pins(i_pins), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_preload(o_preload), .o_extest(o_extest),
  .o_bus_enable(o_bus_enable));

//--- test/bst_tap_tb.sv
`timescale 1ns/1ps
module bst_tap_tb;
  import bst_pkg::*;
  localparam logic [108:0] RING = 109'h1_5A5A_5A5A_C3C3_C3C3_0F0F_9669_123;
  localparam logic [108:0] PAT  = 109'h0_1234_5678_9ABC_DEF0_1357_2468_ACE;
  logic         clock = 1'b0;
  logic         reset_n = 1'b0;
  bst_pins_s    pins;
  logic [108:0] ring = '0;
  logic [108:0] preload;
  logic         tdo, tdo_oe, extest, bus_en, q;
  logic [127:0] dout;
  int           error_cnt = 0;
  int           comparisons = 0;

  bst_tap dut (.i_clock(clock), .i_reset_n(reset_n), .i_pins(pins), .i_ring(ring), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .o_preload(preload), .o_extest(extest), .o_bus_enable(bus_en));
  bst_jtag_master ctl (.i_clock(clock), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_pins(pins));

  // 10 MHz system clock
  initial begin
    forever #50 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // idle to shift, n bits lsb first, update, idle
  task automatic xfer(input bit ir, input int n, input logic [127:0] din);
    dout = '0;
    ctl.step(1'b1, 1'b1, q);
    if (ir) ctl.step(1'b1, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
    chk("tdo float", 1'bz, q);
    for (int i = 0; i < n; i++) begin
      ctl.step(i == n - 1, din[i], dout[i]);
    end
    ctl.step(1'b1, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
  endtask : xfer

  // five mode highs from any state, then idle
  task automatic rst5();
    repeat (5) ctl.step(1'b1, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
  endtask : rst5

  task automatic t_power();
    chk("oe", 1'b0, tdo_oe);
    chk("extest", 1'b0, extest);
    chk("bus", 1'b1, bus_en);
    chk("cell", 1'b1, preload[OE_CELL]);
    // quiet test clock: nothing may move
    repeat (10) @(negedge clock);
    chk("oe idle", 1'b0, tdo_oe);
    ctl.step(1'b0, 1'b1, q);
    $display("test power done");
  endtask : t_power

  task automatic t_ident();
    xfer(1, 3, INS_BYPASS);
    chk("ir capture", 2'b01, dout[1:0]);
    ctl.step(1'b1, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
    rst5();
    xfer(0, 32, '0);
    chk("ident", ID_VALUE_DEF, dout);
    $display("test ident done");
  endtask : t_ident

  task automatic t_bypass();
    xfer(1, 3, INS_BYPASS);
    xfer(0, 4, 4'hB);
    chk("bypass", 4'h6, dout[3:0]);
    // unused code falls back to the bypass bit
    xfer(1, 3, 3'h5);
    xfer(0, 2, 2'h1);
    chk("reserved", 2'h2, dout[1:0]);
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_bound();
    ring = RING;
    xfer(1, 3, INS_SAMPLE);
    xfer(0, 109, PAT);
    chk("capture", RING, dout);
    chk("preload", PAT, preload);
    xfer(1, 3, INS_EXTEST);
    chk("extest", 1'b1, extest);
    chk("bus gate", 1'b0, bus_en);
    // mode reset while the external test is held
    rst5();
    chk("extest rst", 1'b0, extest);
    chk("bus rst", 1'b1, bus_en);
    chk("cell rst", 1'b1, preload[OE_CELL]);
    xfer(1, 3, INS_SAMPLE_Z);
    chk("extest", 1'b0, extest);
    chk("bus z", 1'b0, bus_en);
    ctl.step(1'b1, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
    rst5();
    chk("cell", 1'b1, preload[OE_CELL]);
    chk("bus", 1'b1, bus_en);
    $display("test boundary done");
  endtask : t_bound

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    t_power();
    t_ident();
    t_bypass();
    t_bound();
    complete_run();
  end

  // watchdog
  initial begin
    #3000000;
    error_cnt++;
    complete_run();
  end
endmodule : bst_tap_tb
